// [hw/sps_pin_sync.sv]
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module sps_pin_sync
	import sps_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  clk_en,
	input  wire logic [LANE_COUNT-1:0] pin_in,
	output var  logic [LANE_COUNT-1:0] pin_filt
);

	logic [LANE_COUNT-1:0] meta_reg;
	logic [LANE_COUNT-1:0] sync2_reg;
	logic [LANE_COUNT-1:0] sync3_reg;

	// ------------------------------------------------------------
	// Flop chain
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta_reg  <= LANE_RESET;
			sync2_reg <= LANE_RESET;
			sync3_reg <= LANE_RESET;
		end else if (clk_en) begin
			meta_reg  <= pin_in;
			sync2_reg <= meta_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// ------------------------------------------------------------
	// Accept a change once second and third flops agree
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LANE_COUNT; g++) begin : g_lane
			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					pin_filt[g] <= LANE_RESET[g];
				end else if (clk_en && (sync2_reg[g] == sync3_reg[g])) begin
					pin_filt[g] <= sync3_reg[g];
				end
			end
		end
	endgenerate

endmodule : sps_pin_sync

`default_nettype wire

// [hw/sps_shifter.sv]
// Eight-stage serial-in parallel-out shifter with gated serial input and async clear
//
// Overview of operation
// (RULE_01) Eight cascaded stages, each driven out continuously
// (RULE_02) First stage takes AND of both serial inputs
// (RULE_03) Either serial input low loads a low
// (RULE_04) One input high lets the other decide
// (RULE_05) Stages change only on shift clock rising
// (RULE_06) Clear low empties every stage at once
// (RULE_07) No edge, no clear: stages hold value
// (RULE_08) Each edge moves data one stage onward
// (RULE_09) Driver keeps serial data stable before edge
// (RULE_10) Clear wins over a simultaneous clock edge
`timescale 1ns/1ps
`default_nettype none

module sps_shifter
	import sps_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	input  wire logic                   clk_en,
	input  wire logic                   shift_clk,
	input  wire logic                   serial_a,
	input  wire logic                   serial_b,
	input  wire logic                   async_clear_n,
	output var  logic [STAGE_COUNT-1:0] stage_out,
	output var  logic                   first_stage_out,
	output var  logic                   seventh_stage_out,
	output var  logic                   last_stage_out
);

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic [LANE_COUNT-1:0]  pin_raw;
	logic [LANE_COUNT-1:0]  pin_filt;
	logic                   filt_clk;
	logic                   filt_a;
	logic                   filt_b;
	logic                   filt_clear_n;
	logic                   clk_prev_reg;
	logic                   shift_edge;
	logic                   shift_fire;
	logic                   gate_in;
	logic [STAGE_COUNT-1:0] shift_src;
	logic [STAGE_COUNT-1:0] stage_reg;

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	always_comb begin
		pin_raw           = LANE_RESET;
		pin_raw[LANE_CLK] = shift_clk;
		pin_raw[LANE_A]   = serial_a;
		pin_raw[LANE_B]   = serial_b;
		pin_raw[LANE_CLR] = async_clear_n;
	end

	sps_pin_sync u_pin_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.pin_in   (pin_raw),
		.pin_filt (pin_filt)
	);

	assign filt_clk     = pin_filt[LANE_CLK];
	assign filt_a       = pin_filt[LANE_A];
	assign filt_b       = pin_filt[LANE_B];
	assign filt_clear_n = pin_filt[LANE_CLR];

	// ------------------------------------------------------------
	// Shift clock edge detection
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			clk_prev_reg <= 1'b0;
		end else if (clk_en) begin
			clk_prev_reg <= filt_clk;
		end
	end

	// Only a low-to-high change counts
	assign shift_edge = filt_clk & ~clk_prev_reg; // RULE_05
	// Held clear blocks the edge, also right after release
	assign shift_fire = shift_edge & filt_clear_n & async_clear_n & clk_en; // RULE_10

	// ------------------------------------------------------------
	// Serial gate
	// ------------------------------------------------------------
	// Data pins pass the same filter as the clock, so the setup the
	// driver keeps before its edge carries through to this sample
	assign gate_in = filt_a & filt_b; // RULE_02 RULE_03 RULE_04 RULE_09

	// ------------------------------------------------------------
	// Stage chain
	// ------------------------------------------------------------
	assign shift_src = {stage_reg[STAGE_COUNT-2:0], gate_in}; // RULE_08

	genvar s;
	generate
		for (s = 0; s < STAGE_COUNT; s++) begin : g_stage
			always_ff @(posedge core_clk or posedge reset or negedge async_clear_n) begin
				if (reset || !async_clear_n) begin
					stage_reg[s] <= STAGE_CLEAR[s]; // RULE_06 RULE_10
				end else if (shift_fire) begin
					stage_reg[s] <= shift_src[s]; // RULE_01 RULE_08
				end
			end
		end
	endgenerate
	// No other path writes a stage, so it holds between edges (RULE_07)

	// ------------------------------------------------------------
	// Parallel outputs
	// ------------------------------------------------------------
	assign stage_out         = stage_reg; // RULE_01
	assign first_stage_out   = stage_reg[FIRST_IDX];
	assign seventh_stage_out = stage_reg[SEVENTH_IDX];
	assign last_stage_out    = stage_reg[LAST_IDX];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_named_taps: assert property ( // RULE_01
		@(posedge core_clk) disable iff (reset)
		(first_stage_out == stage_out[FIRST_IDX]) && (seventh_stage_out == stage_out[SEVENTH_IDX])
			&& (last_stage_out == stage_out[LAST_IDX])
	) else $error("Named stage outputs differ from parallel outputs");

	chk_gate_and: assert property ( // RULE_02
		@(posedge core_clk) disable iff (reset || !async_clear_n)
		shift_fire |=> (first_stage_out == ($past(filt_a) & $past(filt_b)))
	) else $error("First stage did not take the AND of the serial inputs");

	chk_gate_block: assert property ( // RULE_03
		@(posedge core_clk) disable iff (reset)
		(shift_fire && (!filt_a || !filt_b)) |=> !first_stage_out
	) else $error("Low serial input did not load a low");

	chk_gate_pass: assert property ( // RULE_04
		@(posedge core_clk) disable iff (reset || !async_clear_n)
		(shift_fire && filt_b) |=> (first_stage_out == $past(filt_a))
	) else $error("With one input high the other did not decide");

	chk_fall_hold: assert property ( // RULE_05
		@(posedge core_clk) disable iff (reset || !async_clear_n)
		(clk_en && !filt_clk && clk_prev_reg) |=> $stable(stage_out)
	) else $error("Stages changed on a falling shift clock");

	chk_clear_empty: assert property ( // RULE_06
		@(posedge core_clk) disable iff (reset)
		!async_clear_n ##1 !async_clear_n |-> (stage_out == STAGE_CLEAR)
	) else $error("Held clear left a stage set");

	chk_idle_hold: assert property ( // RULE_07
		@(posedge core_clk) disable iff (reset || !async_clear_n)
		!shift_fire |=> $stable(stage_out)
	) else $error("Stages changed with no shift edge");

	chk_freeze_hold: assert property ( // RULE_07
		@(posedge core_clk) disable iff (reset || !async_clear_n)
		!clk_en [*2] |-> $stable(stage_out)
	) else $error("Stages changed while the clock enable was low");

	chk_one_shift: assert property ( // RULE_08
		@(posedge core_clk) disable iff (reset || !async_clear_n)
		shift_fire |=> (stage_out[STAGE_COUNT-1:1] == $past(stage_out[STAGE_COUNT-2:0]))
	) else $error("Stages did not move one position");

	chk_clear_wins: assert property ( // RULE_10
		@(posedge core_clk) disable iff (reset || !async_clear_n)
		!filt_clear_n |=> $stable(stage_out)
	) else $error("Shift taken while the filtered clear was still low");

	chk_clear_edge: assert property ( // RULE_10
		@(posedge core_clk) disable iff (reset)
		(shift_edge && !async_clear_n) |=> (stage_out == STAGE_CLEAR)
	) else $error("Shift edge during clear left a stage set");

	chk_clear_now: assert property ( // RULE_06
		@(posedge core_clk) disable iff (reset)
		!async_clear_n |-> (stage_out == STAGE_CLEAR)
	) else $error("Clear low did not empty the stages");

	chk_edge_single: assert property ( // RULE_05
		@(posedge core_clk) disable iff (reset)
		shift_edge && clk_en |=> !shift_edge
	) else $error("One shift clock rise produced two shifts");

endmodule : sps_shifter

`default_nettype wire

// [pkg/sps_pkg.sv]
// Constants shared by the serial-in parallel-out shifter
package sps_pkg;

	// ------------------------------------------------------------
	// Stage layout
	// ------------------------------------------------------------
	localparam int          STAGE_COUNT  = 8;
	localparam int          FIRST_IDX    = 0;
	localparam int          SEVENTH_IDX  = 6;
	localparam int          LAST_IDX     = 7;
	localparam logic [7:0]  STAGE_CLEAR  = 8'h00;

	// ------------------------------------------------------------
	// Pin synchroniser lanes
	// ------------------------------------------------------------
	localparam int          LANE_COUNT   = 4;
	localparam int          LANE_CLK     = 0;
	localparam int          LANE_A       = 1;
	localparam int          LANE_B       = 2;
	localparam int          LANE_CLR     = 3;
	localparam logic [3:0]  LANE_RESET   = 4'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CORE_CLK_MHZ     = 50;
	localparam int          CORE_PERIOD_NS   = 1000 / CORE_CLK_MHZ;
	localparam int          SYNC_STAGES      = 3;

endpackage : sps_pkg

// [sim/sps_drv_model.sv]
// Upstream driver model: serial gate levels and shift clock
`timescale 1ns/1ps
`default_nettype none

module sps_drv_model (
	input  wire logic core_clk,
	output var  logic shift_clk,
	output var  logic serial_a,
	output var  logic serial_b
);
	// ------------------------------------------------------------
	// Shift frame
	// ------------------------------------------------------------
	initial begin
		shift_clk = 1'b0;
		serial_a  = 1'b0;
		serial_b  = 1'b0;
	end

	// Data set up 3 periods before the rise, held until the fall
	task automatic shift(input logic a, input logic b, input int hi);
		@(negedge core_clk);
		serial_a = a;
		serial_b = b;
		repeat (3) @(negedge core_clk);
		shift_clk = 1'b1;
		repeat (hi) @(negedge core_clk);
		shift_clk = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask : shift
endmodule : sps_drv_model

`default_nettype wire

// [sim/tb.sv]
// Self-checking testbench for the serial-in parallel-out shifter
`timescale 1ns/1ps
`default_nettype none

module tb
	import sps_pkg::*;
;
	logic       core_clk = 1'b0;
	logic       reset    = 1'b1;
	logic       clk_en   = 1'b1;
	logic       clr_n    = 1'b1;
	wire logic  shift_clk;
	wire logic  serial_a;
	wire logic  serial_b;
	logic [7:0] stage_out;
	logic       first_o;
	logic       seventh_o;
	logic       last_o;
	logic [7:0] exp = 8'h00;
	int         error_cnt = 0;
	int         cmp_count = 0;

	always #10 core_clk = ~core_clk;

	sps_drv_model drv_u (.core_clk(core_clk), .shift_clk(shift_clk), .serial_a(serial_a), .serial_b(serial_b));

	sps_shifter dut_u (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .shift_clk(shift_clk),
		.serial_a(serial_a), .serial_b(serial_b), .async_clear_n(clr_n), .stage_out(stage_out),
		.first_stage_out(first_o), .seventh_stage_out(seventh_o), .last_stage_out(last_o));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] got);
		cmp_count++;
		if (got !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, e, got);
		end
	endtask : chk

	task automatic end_sim();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk_all();
		chk("stage_out", exp, stage_out);
		chk("first_stage_out", {7'h00, exp[FIRST_IDX]}, {7'h00, first_o});
		chk("seventh_stage_out", {7'h00, exp[SEVENTH_IDX]}, {7'h00, seventh_o});
		chk("last_stage_out", {7'h00, exp[LAST_IDX]}, {7'h00, last_o});
	endtask : chk_all

	task automatic shift_one(input logic a, input logic b, input int hi);
		drv_u.shift(a, b, hi);
		exp = {exp[6:0], a & b};
		chk_all();
	endtask : shift_one

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic sc_gate();
		logic [7:0] a_tab;
		logic [7:0] b_tab;
		a_tab = 8'hB3;
		b_tab = 8'hD5;
		for (int i = 0; i < STAGE_COUNT; i++) begin
			shift_one(a_tab[i], b_tab[i], (i % 2 == 0) ? 4 : 7);
		end
	endtask : sc_gate

	task automatic sc_hold();
		repeat (20) @(negedge core_clk);
		chk("stage_out", exp, stage_out);
	endtask : sc_hold

	task automatic sc_enable();
		clk_en = 1'b0;
		drv_u.shift(1'b1, 1'b1, 7);
		clk_en = 1'b1;
		repeat (6) @(negedge core_clk);
		chk("stage_out", exp, stage_out);
	endtask : sc_enable

	task automatic sc_clear();
		@(negedge core_clk);
		clr_n = 1'b0;
		#1;
		exp = STAGE_CLEAR;
		chk_all();
		drv_u.shift(1'b1, 1'b1, 4);
		clr_n = 1'b1;
		repeat (6) @(negedge core_clk);
		chk("stage_out", exp, stage_out);
		shift_one(1'b1, 1'b1, 4);
	endtask : sc_clear

	initial begin
		repeat (20) @(negedge core_clk);
		reset = 1'b0;
		repeat (6) @(negedge core_clk);
		chk("stage_out", STAGE_CLEAR, stage_out);
		sc_gate();
		sc_hold();
		sc_enable();
		shift_one(1'b1, 1'b1, 4);
		sc_clear();
		end_sim();
	end

	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
endmodule : tb

`default_nettype wire
